// *** shared/pcg_pkg.sv ***
// package for the programmable crc generator: register map, field
// positions, reset values and bus carrier types.
// assumes a 16-bit register port on the same clock as the engine.
package pcg_pkg;

  // register word indexes on the register port
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;
  localparam logic [2:0] ADDR_TAPS_LOW = 3'h2;
  localparam logic [2:0] ADDR_TAPS_HIGH = 3'h3;
  localparam logic [2:0] ADDR_DATA_LOW = 3'h4;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h5;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h6;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h7;

  // control_one field positions
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int POS_COUNT = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SEL = 5;
  localparam int BIT_GO = 4;
  localparam int BIT_LSB_FIRST = 3;

  // control_two field positions
  localparam int POS_DATA_WIDTH = 8;
  localparam int POS_POLY_LENGTH = 0;

  // fifo depths chosen by the data width field
  localparam logic [4:0] DEPTH_WIDE = 5'h04;
  localparam logic [4:0] DEPTH_MID = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] WIDTH_MID_MIN = 5'h08;
  localparam logic [4:0] WIDTH_WIDE_MIN = 5'h10;

  // engine rate and reset values
  localparam int BITS_PER_CYCLE = 2;
  localparam logic [4:0] FIELD_RESET = 5'h00;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // one request on the register port
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_req_type;

endpackage

// *** hw/pcg_crc_engine.sv ***
// programmable crc generator: register file, data fifo, two-bit-per-cycle
// shift engine and completion or count event.
// assumes software on the same clock drives the register port and that
// idle_mode_in comes from the power controller on this clock.
//
// Design decisions made here: the address map and the plain strobed port.

// Notes on behaviour
// - polynomial order up to 32 supported
// - length field holds polynomial length minus one
// - set tap bits add xor feedback
// - x^0 always applied; x^32 implied at 32
// - data width 1..32, field is width-1
// - fifo depth 4, 8 or 16 by width
// - bits above width are ignored
// - count rises when msb-holding half written
// - shift only with go and words waiting
// - pop word to buffer, two bits per cycle
// - full at depth, empty at zero
// - enable low clears fifo, engine, results
// - lsb-first select picks data shift order
// - event select: count 1-to-0 or completion
// - manual go clear raises no event
// - result final some cycles after count event
// - go self-clears on completion, result readable
// - result registers writable to clear or resume
// - idle stop halts engine in idle mode
module pcg_crc_engine (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire pcg_pkg::pcg_bus_req_type bus_in,
  input wire logic idle_mode_in,
  output logic [15:0] rdata_out,
  output logic crc_event_out
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // registers
  logic enable_q;
  logic idle_stop_q;
  logic irq_sel_q;
  logic go_q;
  logic lsb_first_q;
  logic [4:0] width_q;
  logic [4:0] poly_length_field_q;
  logic [31:0] taps_q;
  logic [15:0] data_low_q;
  logic [15:0] data_high_q;
  logic [31:0] result_q;
  logic [31:0] result_d;
  logic [15:0] rdata_q;
  logic event_q;

  // fifo and engine state
  logic [31:0] fifo_mem_q [16];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] count_q;
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [5:0] bits_q;
  logic [5:0] bits_d;

  logic [4:0] depth;
  logic full;
  logic empty;
  logic push;
  logic pop;
  logic run;
  logic finish;
  logic go_write;
  logic [31:0] width_mask;
  logic [31:0] push_word;
  logic [31:0] pop_word;
  logic [31:0] poly_mask;

  assign rst_n = rst_sync_q;

  // reset release through two flops so release is clean on this clock
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // depth and the full flag follow the width field
  always_comb begin
    if (width_q >= pcg_pkg::WIDTH_WIDE_MIN) begin
      depth = pcg_pkg::DEPTH_WIDE;
    end else if (width_q >= pcg_pkg::WIDTH_MID_MIN) begin
      depth = pcg_pkg::DEPTH_MID;
    end else begin
      depth = pcg_pkg::DEPTH_NARROW;
    end
  end
  assign full = (count_q >= depth);
  assign empty = (count_q == pcg_pkg::FIELD_RESET);

  // masks from the configured widths
  assign width_mask = 32'hffff_ffff >> (5'h1f - width_q);
  assign poly_mask = 32'hffff_ffff >> (5'h1f - poly_length_field_q);
  assign push_word = {data_high_q, data_low_q} & width_mask;

  // a word counts once the half holding its msb is written
  always_comb begin
    push = 1'b0;
    if (bus_in.wr && enable_q && !full) begin
      if (width_q[4]) begin
        push = (bus_in.addr == pcg_pkg::ADDR_DATA_HIGH);
      end else begin
        push = (bus_in.addr == pcg_pkg::ADDR_DATA_LOW);
      end
    end
  end

  // engine runs with go unless idle stop holds it
  assign run = enable_q && go_q && !(idle_stop_q && idle_mode_in);
  assign go_write = bus_in.wr && (bus_in.addr == pcg_pkg::ADDR_CONTROL_ONE);

  // one lfsr step: data bit xor top bit feeds every enabled tap
  function automatic logic [31:0] crc_step(input logic [31:0] res,
                                           input logic din,
                                           input logic [31:0] taps,
                                           input logic [4:0] poly_length_field,
                                           input logic [31:0] pmask);
    logic fb;
    logic [31:0] nxt;
    fb = din ^ res[poly_length_field];
    nxt = (res << 1) & pmask;
    if (fb) begin
      nxt = nxt ^ ((taps | 32'h0000_0001) & pmask);
    end
    return nxt;
  endfunction

  // shift up to two bits this cycle, then refill when the buffer drains
  always_comb begin
    result_d = result_q;
    shift_d = shift_q;
    bits_d = bits_q;
    pop = 1'b0;
    finish = 1'b0;
    pop_word = fifo_mem_q[rd_ptr_q];
    if (run) begin
      for (int i = 0; i < pcg_pkg::BITS_PER_CYCLE; i++) begin
        if (bits_d != 6'h00) begin
          if (lsb_first_q) begin
            result_d = crc_step(result_d, shift_d[0], taps_q, poly_length_field_q,
                                poly_mask);
            shift_d = shift_d >> 1;
          end else begin
            result_d = crc_step(result_d, shift_d[31], taps_q, poly_length_field_q,
                                poly_mask);
            shift_d = shift_d << 1;
          end
          bits_d = bits_d - 6'h01;
        end
      end
      if (bits_d == 6'h00 && !empty) begin
        pop = 1'b1;
        bits_d = {1'b0, width_q} + 6'h01;
        if (lsb_first_q) begin
          shift_d = pop_word;
        end else begin
          shift_d = pop_word << (5'h1f - width_q);
        end
      end else if (bits_q != 6'h00 && bits_d == 6'h00) begin
        finish = 1'b1;
      end
    end
  end

  // control_one / control_two / taps: plain software registers
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
      idle_stop_q <= 1'b0;
      irq_sel_q <= 1'b0;
      lsb_first_q <= 1'b0;
      width_q <= pcg_pkg::FIELD_RESET;
      poly_length_field_q <= pcg_pkg::FIELD_RESET;
      taps_q <= pcg_pkg::WORD_RESET;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        pcg_pkg::ADDR_CONTROL_ONE: begin
          enable_q <= bus_in.wdata[pcg_pkg::BIT_ENABLE];
          idle_stop_q <= bus_in.wdata[pcg_pkg::BIT_IDLE_STOP];
          irq_sel_q <= bus_in.wdata[pcg_pkg::BIT_IRQ_SEL];
          lsb_first_q <= bus_in.wdata[pcg_pkg::BIT_LSB_FIRST];
        end
        pcg_pkg::ADDR_CONTROL_TWO: begin
          width_q <= bus_in.wdata[pcg_pkg::POS_DATA_WIDTH +: 5];
          poly_length_field_q <= bus_in.wdata[pcg_pkg::POS_POLY_LENGTH +: 5];
        end
        pcg_pkg::ADDR_TAPS_LOW: begin
          taps_q[15:1] <= bus_in.wdata[15:1];
        end
        pcg_pkg::ADDR_TAPS_HIGH: begin
          taps_q[31:16] <= bus_in.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // go: software write wins over the self-clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else if (go_write) begin
      go_q <= bus_in.wdata[pcg_pkg::BIT_GO];
    end else if (finish && empty) begin
      go_q <= 1'b0;
    end
  end

  // data staging; the high half is cleared with the module
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_low_q <= pcg_pkg::HALF_RESET;
      data_high_q <= pcg_pkg::HALF_RESET;
    end else if (!enable_q) begin
      data_high_q <= pcg_pkg::HALF_RESET;
    end else if (bus_in.wr) begin
      if (bus_in.addr == pcg_pkg::ADDR_DATA_LOW) begin
        data_low_q <= bus_in.wdata;
      end
      if (bus_in.addr == pcg_pkg::ADDR_DATA_HIGH) begin
        data_high_q <= bus_in.wdata;
      end
    end
  end

  // push word is built from the halves including this write
  logic [31:0] push_now;
  always_comb begin
    push_now = push_word;
    if (bus_in.addr == pcg_pkg::ADDR_DATA_LOW) begin
      push_now = {data_high_q, bus_in.wdata} & width_mask;
    end else begin
      push_now = {bus_in.wdata, data_low_q} & width_mask;
    end
  end

  // fifo storage, indexed by the write pointer
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      fifo_mem_q[wr_ptr_q] <= push_now;
    end
  end

  // pointers and word count; disabled module holds them empty
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= pcg_pkg::FIELD_RESET;
    end else if (!enable_q) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= pcg_pkg::FIELD_RESET;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      // push and pop in one cycle leave the count unchanged
      if (push && !pop) begin
        count_q <= count_q + 5'h01;
      end else if (pop && !push) begin
        count_q <= count_q - 5'h01;
      end
    end
  end

  // shift buffer and result; result writes let software clear or resume
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= pcg_pkg::WORD_RESET;
      bits_q <= 6'h00;
      result_q <= pcg_pkg::WORD_RESET;
    end else if (!enable_q) begin
      shift_q <= pcg_pkg::WORD_RESET;
      bits_q <= 6'h00;
      result_q <= pcg_pkg::WORD_RESET;
    end else begin
      shift_q <= shift_d;
      bits_q <= bits_d;
      if (bus_in.wr && bus_in.addr == pcg_pkg::ADDR_RESULT_LOW) begin
        result_q <= {result_d[31:16], bus_in.wdata};
      end else if (bus_in.wr && bus_in.addr == pcg_pkg::ADDR_RESULT_HIGH) begin
        result_q <= {bus_in.wdata, result_d[15:0]};
      end else begin
        result_q <= result_d;
      end
    end
  end

  // completion or count event, one cycle; a manual go clear never reaches here
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else if (irq_sel_q) begin
      event_q <= finish && empty && !go_write;
    end else begin
      // the last word still needs its shift cycles after this pulse
      event_q <= pop && !push && count_q == 5'h01;
    end
  end
  assign crc_event_out = event_q;

  // read mux, answered one cycle after the read strobe
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= pcg_pkg::HALF_RESET;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        pcg_pkg::ADDR_CONTROL_ONE: begin
          rdata_q <= {enable_q, 1'b0, idle_stop_q, count_q, full, empty,
                      irq_sel_q, go_q, lsb_first_q, 3'h0};
        end
        pcg_pkg::ADDR_CONTROL_TWO: begin
          rdata_q <= {3'h0, width_q, 3'h0, poly_length_field_q};
        end
        pcg_pkg::ADDR_TAPS_LOW: begin
          rdata_q <= {taps_q[15:1], 1'b0};
        end
        pcg_pkg::ADDR_TAPS_HIGH: begin
          rdata_q <= taps_q[31:16];
        end
        pcg_pkg::ADDR_DATA_LOW: begin
          rdata_q <= data_low_q;
        end
        pcg_pkg::ADDR_DATA_HIGH: begin
          rdata_q <= data_high_q;
        end
        pcg_pkg::ADDR_RESULT_LOW: begin
          rdata_q <= result_q[15:0];
        end
        pcg_pkg::ADDR_RESULT_HIGH: begin
          rdata_q <= result_q[31:16];
        end
        default: begin
          rdata_q <= pcg_pkg::HALF_RESET;
        end
      endcase
    end else begin
      rdata_q <= pcg_pkg::HALF_RESET;
    end
  end
  assign rdata_out = rdata_q;

  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n);

  chk_count_bounded: assert property (count_q <= depth || !enable_q)
    else $error("word count beyond fifo depth");
  chk_no_shift_idle: assert property (!go_q |=> $stable(result_q)
      || $past(bus_in.wr) || !enable_q)
    else $error("result moved without go");
  chk_disable_clears: assert property (!enable_q |=> count_q == 5'h00
      && result_q == 32'h0000_0000)
    else $error("disabled module kept state");
  chk_idle_halt: assert property (idle_stop_q && idle_mode_in && !bus_in.wr
      |=> $stable(result_q))
    else $error("engine ran while halted in idle");
  chk_two_bits: assert property (run && bits_q >= 6'h02 && !pop
      |=> bits_q == $past(bits_q) - 6'h02)
    else $error("engine did not shift two bits");
  chk_go_holds: assert property (go_q && !empty && !go_write
      |=> go_q)
    else $error("go cleared with words waiting");
  chk_event_sel: assert property (crc_event_out && $past(irq_sel_q)
      |-> !go_q || $past(go_write))
    else $error("completion event with go still set");
  chk_manual_quiet: assert property (go_q && go_write && irq_sel_q
      && !bus_in.wdata[pcg_pkg::BIT_GO] |=> !crc_event_out)
    else $error("manual go clear raised an event");
  chk_push_count: assert property (push && !pop && enable_q
      |=> count_q == $past(count_q) + 5'h01)
    else $error("push did not raise count");

  cov_full: cover property (full && enable_q);
  cov_finish: cover property (finish && empty && irq_sel_q);
  cov_count_event: cover property (crc_event_out && !irq_sel_q);

endmodule

// *** bench/test_programmable_crc_generator.sv ***
// register-level bench for the crc engine: bus tasks, a bit-serial
// reference fold, and scenarios for setup, fifo, events and clearing.
// assumes the engine's own assertions sit inside the design file.
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module test_programmable_crc_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in;
  logic resetn_in;
  logic idle_mode_in;
  pcg_pkg::pcg_bus_req_type bus_q;
  logic [15:0] rdata_out;
  logic crc_event_out;
  int bad_count;
  int n_compared;
  int ev_cnt;
  logic [15:0] rv;
  logic [31:0] expv;
  logic [31:0] wv;

  pcg_crc_engine DUT (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .bus_in(bus_q),
    .idle_mode_in(idle_mode_in),
    .rdata_out(rdata_out),
    .crc_event_out(crc_event_out)
  );

  // 20 mhz clock
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // event pulses are one cycle, so count them per edge
  always @(posedge core_clk_in) begin
    if (crc_event_out === 1'b1) ev_cnt++;
  end

  // reference: msb-first shift register, feedback from the top bit
  function automatic logic [31:0] fold(logic [31:0] r, logic [31:0] d,
      int w, bit lsb, logic [31:0] taps, int poly_length_field);
    logic b;
    logic fb;
    logic [31:0] m;
    m = 32'hffff_ffff >> (31 - poly_length_field);
    for (int i = 0; i < w; i++) begin
      b = lsb ? d[i] : d[w - 1 - i];
      fb = b ^ r[poly_length_field];
      r = (r << 1) & m;
      if (fb) r = r ^ ((taps | 32'h0000_0001) & m);
    end
    return r;
  endfunction

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(posedge core_clk_in);
    bus_q.addr <= a;
    bus_q.wdata <= d;
    bus_q.wr <= 1'b1;
    @(posedge core_clk_in);
    bus_q.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    bus_q.addr <= a;
    bus_q.rd <= 1'b1;
    @(posedge core_clk_in);
    bus_q.rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic chk_rd(logic [2:0] a, logic [15:0] ex, string nm);
    logic [15:0] v;
    rd(a, v);
    `CHK(nm, ex, v)
  endtask

  // poll until the engine drops go; bounded
  task automatic wait_go();
    logic [15:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(pcg_pkg::ADDR_CONTROL_ONE, v);
      if (v[pcg_pkg::BIT_GO] === 1'b0) return;
    end
    bad_count++;
    $display("MISMATCH go never cleared");
    summarize();
  endtask

  initial begin
    bus_q = '0;
    idle_mode_in = 1'b0;
    resetn_in = 1'b0;
    ev_cnt = 0;
    bad_count = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    // reset values
    chk_rd(3'h0, 16'h0040, "reset ctrl1");
    for (int a = 1; a < 8; a++) begin
      chk_rd(a[2:0], 16'h0000, "reset reg");
    end
    // crc-16, 8-bit words msb first, count event
    wr(3'h0, 16'h8000);
    wr(3'h2, 16'h1021);
    chk_rd(3'h2, 16'h1020, "tap bit0");
    wr(3'h1, 16'h070f);
    expv = '0;
    for (int i = 0; i < 17; i++) begin
      wv = 32'(i * 29 + 3);
      wr(3'h4, {8'hab, wv[7:0]});
      if (i < 16) expv = fold(expv, wv, 8, 1'b0, 32'h1021, 15);
    end
    chk_rd(3'h0, 16'h9080, "full 16");
    wr(3'h6, 16'h0000);
    wr(3'h7, 16'h0000);
    wr(3'h0, 16'h8010);
    wait_go();
    `CHK("ev count", 1, ev_cnt)
    chk_rd(3'h6, expv[15:0], "crc16");
    chk_rd(3'h7, 16'h0000, "crc16 hi");
    chk_rd(3'h0, 16'h8040, "empty");
    // crc-32, 32-bit lsb first, completion event, then resume
    wr(3'h1, 16'h1f1f);
    wr(3'h2, 16'h1db7);
    wr(3'h3, 16'h04c1);
    // lsb first and completion event chosen before any data goes in
    wr(3'h0, 16'h8028);
    wr(3'h6, 16'h0000);
    wr(3'h7, 16'h0000);
    expv = '0;
    for (int k = 0; k < 2; k++) begin
      wv = 32'hc3a5_0f81 ^ (k * 32'h1111_0000);
      wr(3'h4, wv[15:0]);
      chk_rd(3'h0, 16'h8068, "low half");
      wr(3'h5, wv[31:16]);
      chk_rd(3'h0, 16'h8128, "high half");
      expv = fold(expv, wv, 32, 1'b1, 32'h04c1_1db7, 31);
      wr(3'h0, 16'h8038);
      wait_go();
      `CHK("ev sel1", k + 2, ev_cnt)
      chk_rd(3'h6, expv[15:0], "crc32 lo");
      chk_rd(3'h7, expv[31:16], "crc32 hi");
    end
    // 16-bit words: depth 8, idle stall, manual stop, disable
    wr(3'h1, 16'h0f07);
    for (int i = 0; i < 8; i++) wr(3'h4, 16'h5a00 + 16'(i));
    chk_rd(3'h0, 16'h88a8, "full 8");
    // idle level changes on a clock edge, like every other input
    @(posedge core_clk_in);
    idle_mode_in <= 1'b1;
    wr(3'h0, 16'ha030);
    repeat (20) @(posedge core_clk_in);
    chk_rd(3'h0, 16'ha8b0, "idle hold");
    wr(3'h0, 16'ha020);
    idle_mode_in <= 1'b0;
    repeat (30) @(posedge core_clk_in);
    chk_rd(3'h0, 16'ha8a0, "no shift");
    `CHK("no event", 3, ev_cnt)
    wr(3'h0, 16'h0000);
    chk_rd(3'h0, 16'h0040, "disabled");
    chk_rd(3'h1, 16'h0f07, "cfg kept");
    chk_rd(3'h6, 16'h0000, "result clr");
    chk_rd(3'h5, 16'h0000, "data hi clr");
    summarize();
  end
endmodule
